// *** src/iem_pkg.sv ***
// Constants and types for the interrupt enable and masking stage
package iem_pkg;

   localparam int IEM_NUM_SRC = 18;

   // Register addresses on the special function register port
   localparam logic [7:0] IEM_EXT_MASK_ADDR = 8'h9b;
   localparam logic [7:0] IEM_EXT_MASK_2_ADDR = 8'h9c;
   localparam logic [7:0] IEM_PRI_MASK_ADDR = 8'ha8;

   // Reset values
   localparam logic [7:0] IEM_EXT_MASK_RST = 8'h00;
   localparam logic [7:0] IEM_EXT_MASK_2_RST = 8'h00;
   localparam logic [7:0] IEM_PRI_MASK_RST = 8'h00;

   // Implemented bits of the third register; upper bits read zero
   localparam logic [7:0] IEM_EXT_MASK_2_USED = 8'h07;

   // Bit positions, primary_source_mask
   localparam int IEM_GLOBAL_GATE_BIT = 7;
   localparam int IEM_ADC_BIT = 6;
   localparam int IEM_BROWNOUT_BIT = 5;
   localparam int IEM_UART0_BIT = 4;
   localparam int IEM_TMR1_BIT = 3;
   localparam int IEM_XINT1_BIT = 2;
   localparam int IEM_TMR0_BIT = 1;
   localparam int IEM_XINT0_BIT = 0;

   // Bit positions, extended_source_mask
   localparam int IEM_TMR2_BIT = 7;
   localparam int IEM_SPI_BIT = 6;
   localparam int IEM_BRAKE_BIT = 5;
   localparam int IEM_WDOG_BIT = 4;
   localparam int IEM_PWM_BIT = 3;
   localparam int IEM_CAPTURE_BIT = 2;
   localparam int IEM_PINCHG_BIT = 1;
   localparam int IEM_TWOWIRE_BIT = 0;

   // Bit positions, extended_source_mask_2
   localparam int IEM_WAKEUP_TMR_BIT = 2;
   localparam int IEM_TMR3_BIT = 1;
   localparam int IEM_UART1_BIT = 0;

   // Request line index of each source, equal to its vector number
   localparam int IEM_SRC_XINT0 = 0;
   localparam int IEM_SRC_TMR0 = 1;
   localparam int IEM_SRC_XINT1 = 2;
   localparam int IEM_SRC_TMR1 = 3;
   localparam int IEM_SRC_UART0 = 4;
   localparam int IEM_SRC_TMR2 = 5;
   localparam int IEM_SRC_TWOWIRE = 6;
   localparam int IEM_SRC_PINCHG = 7;
   localparam int IEM_SRC_BROWNOUT = 8;
   localparam int IEM_SRC_SPI = 9;
   localparam int IEM_SRC_WDOG = 10;
   localparam int IEM_SRC_ADC = 11;
   localparam int IEM_SRC_CAPTURE = 12;
   localparam int IEM_SRC_PWM = 13;
   localparam int IEM_SRC_BRAKE = 14;
   localparam int IEM_SRC_UART1 = 15;
   localparam int IEM_SRC_TMR3 = 16;
   localparam int IEM_SRC_WAKEUP_TMR = 17;

   // Peripheral flag levels, as held in the peripherals' own registers
   typedef struct packed {
      logic xint0;
      logic tmr0;
      logic xint1;
      logic tmr1;
      logic uart0_tx_done;
      logic uart0_rx_done;
      logic tmr2;
      logic twowire_state;
      logic twowire_timeout_flag;
      logic [7:0] pinchg_flags;
      logic brownout;
      logic spi_xfer_done;
      logic spi_overrun;
      logic spi_mode_fault;
      logic wdog;
      logic adc;
      logic [2:0] capture_flags;
      logic pwm;
      logic brake;
      logic uart1_tx_done;
      logic uart1_rx_done;
      logic tmr3;
      logic wakeup_tmr;
   } iem_flags_type;

   // Special function register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } iem_sfr_req_type;

endpackage

// *** src/iem_enable_mask.sv ***
// Interrupt enable registers and per-source request gating
`timescale 1ns/1ps
`default_nettype none

module iem_enable_mask
   import iem_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire iem_sfr_req_type sfr_req_in,
   input wire iem_flags_type flags_in,
   output logic [7:0] sfr_rdata_out,
   output logic [IEM_NUM_SRC-1:0] irq_req_out,
   output logic [IEM_NUM_SRC-1:0] irq_pending_out
);

   logic [7:0] primary_source_mask;
   logic [7:0] extended_source_mask;
   logic [7:0] extended_source_mask_2;

   wire logic hit_pri;
   wire logic hit_ext;
   wire logic hit_ext_2;
   wire logic [7:0] next_rdata;
   wire logic global_gate;
   wire logic [IEM_NUM_SRC-1:0] src_flag;
   wire logic [IEM_NUM_SRC-1:0] src_on;
   wire logic [IEM_NUM_SRC-1:0] next_req;
   wire logic [IEM_NUM_SRC-1:0] next_pending;

   assign hit_pri = (sfr_req_in.addr == IEM_PRI_MASK_ADDR);
   assign hit_ext = (sfr_req_in.addr == IEM_EXT_MASK_ADDR);
   assign hit_ext_2 = (sfr_req_in.addr == IEM_EXT_MASK_2_ADDR);

   // Unmapped addresses read zero so the core's read mux can simply OR slaves
   assign next_rdata = hit_pri ? primary_source_mask :
                       hit_ext ? extended_source_mask :
                       hit_ext_2 ? (extended_source_mask_2 & IEM_EXT_MASK_2_USED) :
                       8'h00;

   // Enable registers; bit-addressable writes arrive as whole-byte read-modify-write
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         primary_source_mask <= IEM_PRI_MASK_RST;
         extended_source_mask <= IEM_EXT_MASK_RST;
         extended_source_mask_2 <= IEM_EXT_MASK_2_RST;
      end
      else if (sfr_req_in.wr)
      begin
         if (hit_pri)
         begin
            primary_source_mask <= sfr_req_in.wdata;
         end
         else if (hit_ext)
         begin
            extended_source_mask <= sfr_req_in.wdata;
         end
         else if (hit_ext_2)
         begin
            extended_source_mask_2 <= sfr_req_in.wdata & IEM_EXT_MASK_2_USED;
         end
      end
   end

   assign global_gate = primary_source_mask[IEM_GLOBAL_GATE_BIT];

   // Flags are plain levels; a software write of 1 in the peripheral looks the same here
   assign src_flag[IEM_SRC_XINT0] = flags_in.xint0;
   assign src_flag[IEM_SRC_TMR0] = flags_in.tmr0;
   assign src_flag[IEM_SRC_XINT1] = flags_in.xint1;
   assign src_flag[IEM_SRC_TMR1] = flags_in.tmr1;
   assign src_flag[IEM_SRC_UART0] = flags_in.uart0_tx_done | flags_in.uart0_rx_done;
   assign src_flag[IEM_SRC_TMR2] = flags_in.tmr2;
   assign src_flag[IEM_SRC_TWOWIRE] = flags_in.twowire_state | flags_in.twowire_timeout_flag;
   assign src_flag[IEM_SRC_PINCHG] = |flags_in.pinchg_flags;
   assign src_flag[IEM_SRC_BROWNOUT] = flags_in.brownout;
   assign src_flag[IEM_SRC_SPI] = flags_in.spi_xfer_done | flags_in.spi_overrun | flags_in.spi_mode_fault;
   assign src_flag[IEM_SRC_WDOG] = flags_in.wdog;
   assign src_flag[IEM_SRC_ADC] = flags_in.adc;
   assign src_flag[IEM_SRC_CAPTURE] = |flags_in.capture_flags;
   assign src_flag[IEM_SRC_PWM] = flags_in.pwm;
   assign src_flag[IEM_SRC_BRAKE] = flags_in.brake;
   assign src_flag[IEM_SRC_UART1] = flags_in.uart1_tx_done | flags_in.uart1_rx_done;
   assign src_flag[IEM_SRC_TMR3] = flags_in.tmr3;
   assign src_flag[IEM_SRC_WAKEUP_TMR] = flags_in.wakeup_tmr;

   // Per-source enable bits mapped onto request line order
   assign src_on[IEM_SRC_XINT0] = primary_source_mask[IEM_XINT0_BIT];
   assign src_on[IEM_SRC_TMR0] = primary_source_mask[IEM_TMR0_BIT];
   assign src_on[IEM_SRC_XINT1] = primary_source_mask[IEM_XINT1_BIT];
   assign src_on[IEM_SRC_TMR1] = primary_source_mask[IEM_TMR1_BIT];
   assign src_on[IEM_SRC_UART0] = primary_source_mask[IEM_UART0_BIT];
   assign src_on[IEM_SRC_TMR2] = extended_source_mask[IEM_TMR2_BIT];
   assign src_on[IEM_SRC_TWOWIRE] = extended_source_mask[IEM_TWOWIRE_BIT];
   assign src_on[IEM_SRC_PINCHG] = extended_source_mask[IEM_PINCHG_BIT];
   assign src_on[IEM_SRC_BROWNOUT] = primary_source_mask[IEM_BROWNOUT_BIT];
   assign src_on[IEM_SRC_SPI] = extended_source_mask[IEM_SPI_BIT];
   assign src_on[IEM_SRC_WDOG] = extended_source_mask[IEM_WDOG_BIT];
   assign src_on[IEM_SRC_ADC] = primary_source_mask[IEM_ADC_BIT];
   assign src_on[IEM_SRC_CAPTURE] = extended_source_mask[IEM_CAPTURE_BIT];
   assign src_on[IEM_SRC_PWM] = extended_source_mask[IEM_PWM_BIT];
   assign src_on[IEM_SRC_BRAKE] = extended_source_mask[IEM_BRAKE_BIT];
   assign src_on[IEM_SRC_UART1] = extended_source_mask_2[IEM_UART1_BIT];
   assign src_on[IEM_SRC_TMR3] = extended_source_mask_2[IEM_TMR3_BIT];
   assign src_on[IEM_SRC_WAKEUP_TMR] = extended_source_mask_2[IEM_WAKEUP_TMR_BIT];

   // Gating holds no state: a flag seen under a closed gate is still there when it
   // opens, so pending is kept by the peripheral flag until software clears it
   genvar gi;
   generate
      for (gi = 0; gi < IEM_NUM_SRC; gi++)
      begin : g_src
         assign next_pending[gi] = src_flag[gi] & src_on[gi];
         assign next_req[gi] = next_pending[gi] & global_gate;
      end
   endgenerate

   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         irq_req_out <= '0;
         irq_pending_out <= '0;
         sfr_rdata_out <= 8'h00;
      end
      else
      begin
         irq_req_out <= next_req;
         irq_pending_out <= next_pending;
         sfr_rdata_out <= next_rdata;
      end
   end

endmodule

`default_nettype wire

// *** verif/iem_core_model.sv ***
// Core-side model driving the special function register port
`timescale 1ns/1ps
`default_nettype none
module iem_core_model
   import iem_pkg::*;
(
   input wire logic ref_clk_in,
   output var iem_sfr_req_type sfr_req_out
);
   initial sfr_req_out = '0;
   // One-cycle write; data is scrambled after so a late sample shows up
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      sfr_req_out = '{addr: a, wr: 1'b1, wdata: d};
      @(negedge ref_clk_in);
      sfr_req_out.wr = 1'b0;
      sfr_req_out.wdata = ~d;
   endtask
   task automatic look(input logic [7:0] a);
      @(negedge ref_clk_in);
      sfr_req_out.addr = a;
      @(negedge ref_clk_in);
   endtask
endmodule
`default_nettype wire

// *** verif/iem_enable_mask_asserts.sv ***
// Port assertions for the enable and masking stage
`timescale 1ns/1ps
`default_nettype none
module iem_enable_mask_asserts
   import iem_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire iem_sfr_req_type sfr_req_in,
   input wire iem_flags_type flags_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic [IEM_NUM_SRC-1:0] irq_req_out,
   input wire logic [IEM_NUM_SRC-1:0] irq_pending_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence wr_pri_s;
      sfr_req_in.wr && sfr_req_in.addr == IEM_PRI_MASK_ADDR ##1 sfr_req_in.addr == IEM_PRI_MASK_ADDR;
   endsequence
   AST_PRI_READBACK: assert property (wr_pri_s |=> sfr_rdata_out == $past(sfr_req_in.wdata, 2))
      else $error("primary mask readback wrong");
   AST_EXT2_UNUSED: assert property ($past(sfr_req_in.addr) == IEM_EXT_MASK_2_ADDR |-> sfr_rdata_out[7:3] == 5'h00)
      else $error("unused bits not zero");
   AST_REQ_SUBSET: assert property ((irq_req_out & ~irq_pending_out) == '0)
      else $error("request without enable");
   AST_GATE_ALL: assert property (irq_req_out == '0 || irq_req_out == irq_pending_out)
      else $error("gate applied per source");
   AST_UART0: assert property (irq_pending_out[IEM_SRC_UART0] |-> $past(flags_in.uart0_tx_done | flags_in.uart0_rx_done))
      else $error("uart0 request without flag");
   AST_SPI: assert property (irq_pending_out[IEM_SRC_SPI] |->
      $past(flags_in.spi_xfer_done | flags_in.spi_overrun | flags_in.spi_mode_fault))
      else $error("spi request without flag");
   AST_CAPTURE: assert property (irq_pending_out[IEM_SRC_CAPTURE] |-> $past(|flags_in.capture_flags))
      else $error("capture request without flag");
   AST_PINCHG: assert property (irq_pending_out[IEM_SRC_PINCHG] |-> $past(|flags_in.pinchg_flags))
      else $error("pin change request without flag");
   AST_TWOWIRE: assert property (irq_pending_out[IEM_SRC_TWOWIRE] |->
      $past(flags_in.twowire_state | flags_in.twowire_timeout_flag))
      else $error("two-wire request without flag");
   AST_UART1: assert property (irq_pending_out[IEM_SRC_UART1] |-> $past(flags_in.uart1_tx_done | flags_in.uart1_rx_done))
      else $error("uart1 request without flag");
   AST_ADC_DROP: assert property ($fell(flags_in.adc) |=> !irq_req_out[IEM_SRC_ADC])
      else $error("adc request outlived flag");
endmodule
`default_nettype wire

// *** verif/interrupt_enable_masking_tb.sv ***
// Self-checking bench for the enable and masking stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module interrupt_enable_masking_tb
   import iem_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   iem_sfr_req_type sfr_req;
   iem_flags_type flags = '0;
   logic [7:0] rdata;
   logic [17:0] req;
   logic [17:0] pend;
   logic [7:0] p = 8'h00;
   logic [7:0] e = 8'h00;
   logic [7:0] e2 = 8'h00;
   int bad_count = 0;
   int compares = 0;
   always #12.5 ref_clk_in = ~ref_clk_in;
   iem_core_model u_iem_core_model (.ref_clk_in(ref_clk_in), .sfr_req_out(sfr_req));
   iem_enable_mask u_iem_enable_mask (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .sfr_req_in(sfr_req),
      .flags_in(flags), .sfr_rdata_out(rdata), .irq_req_out(req), .irq_pending_out(pend));
   function automatic logic [17:0] exp_pend(iem_flags_type f);
      return {f.wakeup_tmr & e2[2], f.tmr3 & e2[1], (f.uart1_tx_done | f.uart1_rx_done) & e2[0], f.brake & e[5],
         f.pwm & e[3], |f.capture_flags & e[2], f.adc & p[6], f.wdog & e[4],
         (f.spi_xfer_done | f.spi_overrun | f.spi_mode_fault) & e[6], f.brownout & p[5], |f.pinchg_flags & e[1],
         (f.twowire_state | f.twowire_timeout_flag) & e[0], f.tmr2 & e[7], (f.uart0_tx_done | f.uart0_rx_done) & p[4],
         f.tmr1 & p[3], f.xint1 & p[2], f.tmr0 & p[1], f.xint0 & p[0]};
   endfunction
   task automatic end_of_test;
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic set_all(input logic [7:0] np, input logic [7:0] ne, input logic [7:0] ne2);
      p = np;
      e = ne;
      e2 = ne2 & IEM_EXT_MASK_2_USED;
      u_iem_core_model.put(IEM_PRI_MASK_ADDR, np);
      u_iem_core_model.put(IEM_EXT_MASK_ADDR, ne);
      u_iem_core_model.put(IEM_EXT_MASK_2_ADDR, ne2);
   endtask
   task automatic chk_irq(input iem_flags_type f);
      @(negedge ref_clk_in);
      flags = f;
      @(negedge ref_clk_in);
      `CHK("pending", exp_pend(f), pend)
      `CHK("request", exp_pend(f) & {18{p[7]}}, req)
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] x);
      u_iem_core_model.look(a);
      `CHK("sfr read", x, rdata)
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk_in);
      bad_count++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(1));
      repeat (2) @(negedge ref_clk_in);
      reset_n_in = 1'b1;
      chk_reg(IEM_PRI_MASK_ADDR, IEM_PRI_MASK_RST);
      chk_reg(IEM_EXT_MASK_ADDR, IEM_EXT_MASK_RST);
      chk_reg(IEM_EXT_MASK_2_ADDR, IEM_EXT_MASK_2_RST);
      chk_reg(8'ha9, 8'h00);
      chk_irq('1);
      // Gate closed: everything pending, nothing requested until it opens
      set_all(8'h7f, 8'hff, 8'hff);
      chk_reg(IEM_EXT_MASK_2_ADDR, 8'h07);
      chk_irq('1);
      set_all(8'hff, 8'hff, 8'hff);
      chk_irq('1);
      // Each flag bit alone, then cleared by software
      for (int i = 0; i < 32; i++)
         chk_irq(iem_flags_type'(32'h1 << i));
      chk_irq('0);
      repeat (200)
      begin
         set_all(8'($urandom()), 8'($urandom()), 8'($urandom()));
         chk_irq(iem_flags_type'($urandom() & $urandom()));
         chk_reg(IEM_EXT_MASK_ADDR, e);
      end
      // Reset in mid-run must clear every enable and drop every line
      set_all(8'hff, 8'hff, 8'hff);
      @(negedge ref_clk_in);
      reset_n_in = 1'b0;
      p = IEM_PRI_MASK_RST;
      e = IEM_EXT_MASK_RST;
      e2 = IEM_EXT_MASK_2_RST;
      @(negedge ref_clk_in);
      reset_n_in = 1'b1;
      chk_reg(IEM_PRI_MASK_ADDR, IEM_PRI_MASK_RST);
      chk_reg(IEM_EXT_MASK_2_ADDR, IEM_EXT_MASK_2_RST);
      chk_irq('1);
      end_of_test();
   end
endmodule
bind iem_enable_mask iem_enable_mask_asserts u_asserts (.ref_clk_in, .reset_n_in, .sfr_req_in, .flags_in,
   .sfr_rdata_out, .irq_req_out, .irq_pending_out);
`default_nettype wire
